/* artc_pkg.sv */
// Shared constants, register map and field types for the auto-reload timer control block
package artc_pkg;
    localparam int unsigned ARTC_SYS_HZ = 25_000_000;
    localparam logic [7:0] ARTC_OFF_RELOAD = 8'h00;
    localparam logic [7:0] ARTC_OFF_COUNT = 8'h04;
    localparam logic [7:0] ARTC_OFF_CLKSEL = 8'h08;
    localparam logic [7:0] ARTC_OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ARTC_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] ARTC_OFF_CTRL = 8'hC8;
    localparam int ARTC_BIT_HFLAG = 7;
    localparam int ARTC_BIT_LFLAG = 6;
    localparam int ARTC_BIT_LIEN = 5;
    localparam int ARTC_BIT_SPLIT = 3;
    localparam int ARTC_BIT_RUN = 2;
    localparam int ARTC_BIT_XCLK = 0;
    localparam int ARTC_IRQ_HIGH = 0;
    localparam int ARTC_IRQ_LOW = 1;
    localparam int ARTC_CLKSEL_LOW = 0;
    localparam int ARTC_CLKSEL_HIGH = 1;
    localparam logic [7:0] ARTC_CTRL_RESET = 8'h00;
    localparam logic [15:0] ARTC_RELOAD_RESET = 16'h0000;
    localparam logic [7:0] ARTC_BYTE_MAX = 8'hFF;
    localparam logic [15:0] ARTC_WORD_MAX = 16'hFFFF;
    localparam logic [3:0] ARTC_SYS_DIV = 4'hC;
    localparam logic [2:0] ARTC_EXT_DIV_LAST = 3'h7;
    localparam logic [1:0] ARTC_HTRANS_NONSEQ = 2'h2;
    localparam logic ARTC_HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic high_byte_overflow_flag;
        logic low_byte_overflow_flag;
        logic low_byte_irq_enable;
        logic split_mode_select;
        logic run_control;
        logic ext_clock_select;
    } artc_ctrl_t;

    function automatic logic [7:0] artc_ctrl_pack(input artc_ctrl_t c);
        logic [7:0] v;
        v = 8'h00;
        v[ARTC_BIT_HFLAG] = c.high_byte_overflow_flag;
        v[ARTC_BIT_LFLAG] = c.low_byte_overflow_flag;
        v[ARTC_BIT_LIEN] = c.low_byte_irq_enable;
        v[ARTC_BIT_SPLIT] = c.split_mode_select;
        v[ARTC_BIT_RUN] = c.run_control;
        v[ARTC_BIT_XCLK] = c.ext_clock_select;
        return v;
    endfunction : artc_ctrl_pack
endpackage : artc_pkg

/* artc_clk_src.sv */
// Timer clock-source prescaler: system clock / 12 or synchronised external clock / 8
module artc_clk_src
    import artc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ext_clock_select,
    input wire logic ext_clk_pin,
    output logic ext_tick
);
    logic [2:0] sync_q;
    logic [3:0] sys_div_q;
    logic [2:0] ext_div_q;
    logic sys_tick;
    logic ext_edge;
    logic ext_level_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], ext_clk_pin};
        end
    end

    // Level follows the pin only once stages two and three agree, so a level seen
    // by one stage alone never counts as an edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            ext_level_q <= sync_q[2];
        end
    end
    assign ext_edge = sync_q[1] & sync_q[2] & ~ext_level_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_div_q <= 4'h0;
        end else if (sys_div_q == ARTC_SYS_DIV - 4'h1) begin
            sys_div_q <= 4'h0;
        end else begin
            sys_div_q <= sys_div_q + 4'h1;
        end
    end
    assign sys_tick = (sys_div_q == ARTC_SYS_DIV - 4'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_div_q <= 3'h0;
        end else if (ext_edge) begin
            ext_div_q <= ext_div_q + 3'h1;
        end
    end

    // one source choice shared by both bytes
    assign ext_tick = ext_clock_select ? (ext_edge && ext_div_q == ARTC_EXT_DIV_LAST) : sys_tick;

    AST_SYS_DIV12: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ext_clock_select && sys_tick) |-> ##12 sys_tick)
        else $error("system clock divide by twelve broken");
    AST_EXT_DIV8: assert property (@(posedge hclk) disable iff (!hresetn)
        (ext_clock_select && ext_tick) |=> (ext_div_q == 3'h0))
        else $error("external clock divide by eight broken");
endmodule : artc_clk_src

/* artc_timer.sv */
// Auto-reload timer control block with AHB-Lite register access and interrupt
module artc_timer
    import artc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ext_clk_pin,
    output logic irq
);
    artc_ctrl_t ctrl_q;
    artc_ctrl_t ctrl_d;
    logic [7:0] count_low_byte_q;
    logic [7:0] count_high_byte_q;
    logic [7:0] reload_low_q;
    logic [7:0] reload_high_q;
    logic low_byte_clock_select_q;
    logic high_byte_clock_select_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic ext_tick;
    logic tick_low;
    logic tick_high;
    logic inc_low;
    logic inc_high;
    logic ovf_low;
    logic ovf_high;
    logic wr_ctrl;
    logic wr_reload;
    logic wr_count;
    logic wr_clksel;
    logic wr_status;
    logic wr_mask;
    logic [15:0] count_word;

    function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
        return pend && (a == off);
    endfunction : wr_hit

    artc_clk_src u_clk_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .ext_clock_select(ctrl_q.ext_clock_select),
        .ext_clk_pin(ext_clk_pin),
        .ext_tick(ext_tick)
    );

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = ARTC_HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans == ARTC_HTRANS_NONSEQ && hwrite && (haddr[31:8] == 24'h0);
            rd_pend_q <= hsel && htrans == ARTC_HTRANS_NONSEQ && !hwrite && (haddr[31:8] == 24'h0);
            addr_q <= {haddr[7:2], 2'b00};
        end
    end

    assign wr_ctrl = wr_hit(wr_pend_q, addr_q, ARTC_OFF_CTRL);
    assign wr_reload = wr_hit(wr_pend_q, addr_q, ARTC_OFF_RELOAD);
    assign wr_count = wr_hit(wr_pend_q, addr_q, ARTC_OFF_COUNT);
    assign wr_clksel = wr_hit(wr_pend_q, addr_q, ARTC_OFF_CLKSEL);
    assign wr_status = wr_hit(wr_pend_q, addr_q, ARTC_OFF_IRQ_STATUS);
    assign wr_mask = wr_hit(wr_pend_q, addr_q, ARTC_OFF_IRQ_MASK);
    assign count_word = {count_high_byte_q, count_low_byte_q};

    // Read mux sits on flops only; unmapped words read zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend_q) begin
            case (addr_q)
                ARTC_OFF_RELOAD: hrdata = {16'h0000, reload_high_q, reload_low_q};
                ARTC_OFF_COUNT: hrdata = {16'h0000, count_word};
                ARTC_OFF_CLKSEL: hrdata = {30'h0, high_byte_clock_select_q, low_byte_clock_select_q};
                ARTC_OFF_IRQ_STATUS: hrdata = {30'h0, irq_status_q};
                ARTC_OFF_IRQ_MASK: hrdata = {30'h0, irq_mask_q};
                ARTC_OFF_CTRL: hrdata = {24'h000000, artc_ctrl_pack(ctrl_q)};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // per-byte choice between undivided system clock and the prescaled tick
    assign tick_low = low_byte_clock_select_q ? 1'b1 : ext_tick;
    assign tick_high = high_byte_clock_select_q ? 1'b1 : ext_tick;

    assign inc_low = ctrl_q.split_mode_select ? tick_low : (ctrl_q.run_control & tick_low);
    assign inc_high = ctrl_q.split_mode_select ? (ctrl_q.run_control & tick_high) : inc_low;
    assign ovf_low = inc_low && count_low_byte_q == ARTC_BYTE_MAX;
    assign ovf_high = ctrl_q.split_mode_select ? (inc_high && count_high_byte_q == ARTC_BYTE_MAX)
                                               : (inc_low && count_word == ARTC_WORD_MAX);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_low_byte_q <= 8'h00;
            count_high_byte_q <= 8'h00;
        end else if (wr_count) begin
            count_low_byte_q <= hwdata[7:0];
            count_high_byte_q <= hwdata[15:8];
        end else if (ctrl_q.split_mode_select) begin
            if (inc_low) begin
                count_low_byte_q <= ovf_low ? reload_low_q : count_low_byte_q + 8'h01;
            end
            if (inc_high) begin
                count_high_byte_q <= ovf_high ? reload_high_q : count_high_byte_q + 8'h01;
            end
        end else if (inc_low) begin
            if (ovf_high) begin
                count_low_byte_q <= reload_low_q;
                count_high_byte_q <= reload_high_q;
            end else begin
                count_low_byte_q <= count_low_byte_q + 8'h01;
                count_high_byte_q <= count_high_byte_q + {7'h00, ovf_low};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_low_q <= ARTC_RELOAD_RESET[7:0];
            reload_high_q <= ARTC_RELOAD_RESET[15:8];
        end else if (wr_reload) begin
            reload_low_q <= hwdata[7:0];
            reload_high_q <= hwdata[15:8];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_byte_clock_select_q <= 1'b0;
            high_byte_clock_select_q <= 1'b0;
        end else if (wr_clksel) begin
            low_byte_clock_select_q <= hwdata[ARTC_CLKSEL_LOW];
            high_byte_clock_select_q <= hwdata[ARTC_CLKSEL_HIGH];
        end
    end

    // Flags: software writes 0 to clear; a hardware set in the same cycle wins
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.high_byte_overflow_flag = hwdata[ARTC_BIT_HFLAG];
            ctrl_d.low_byte_overflow_flag = hwdata[ARTC_BIT_LFLAG];
            ctrl_d.low_byte_irq_enable = hwdata[ARTC_BIT_LIEN];
            ctrl_d.split_mode_select = hwdata[ARTC_BIT_SPLIT];
            ctrl_d.run_control = hwdata[ARTC_BIT_RUN];
            ctrl_d.ext_clock_select = hwdata[ARTC_BIT_XCLK];
        end
        if (ovf_high) begin
            ctrl_d.high_byte_overflow_flag = 1'b1;
        end
        if (ovf_low) begin
            ctrl_d.low_byte_overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= artc_ctrl_t'(ARTC_CTRL_RESET[5:0]);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Sticky event bits, write one to clear, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_q <= 2'h0;
        end else begin
            irq_status_q <= (irq_status_q & ~(wr_status ? hwdata[1:0] : 2'h0)) | {ovf_low, ovf_high};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_q <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_q <= hwdata[1:0];
        end
    end

    // mask acts as timer interrupt enable; low also needs its enable
    assign irq = (irq_status_q[ARTC_IRQ_HIGH] & irq_mask_q[ARTC_IRQ_HIGH])
               | (irq_status_q[ARTC_IRQ_LOW] & irq_mask_q[ARTC_IRQ_LOW] & ctrl_q.low_byte_irq_enable);

    AST_HFLAG_SPLIT: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.split_mode_select && inc_high && count_high_byte_q == 8'hFF && !wr_count)
        |=> (ctrl_q.high_byte_overflow_flag && count_high_byte_q == $past(reload_high_q)))
        else $error("high byte rollover missed flag or reload");

    AST_WRAP_16: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_q.split_mode_select && inc_low && count_word == 16'hFFFF && !wr_count)
        |=> (ctrl_q.high_byte_overflow_flag && irq_status_q[0]))
        else $error("16-bit rollover missed high flag");

    AST_RELOAD_16: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_q.split_mode_select && ovf_high && !wr_count)
        |=> (count_word == {$past(reload_high_q), $past(reload_low_q)}))
        else $error("16-bit reload wrong");

    AST_IRQ_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_status_q[0] && irq_mask_q[0]) |-> irq)
        else $error("enabled high overflow gave no interrupt");

    AST_HFLAG_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.high_byte_overflow_flag && !wr_ctrl) |=> ctrl_q.high_byte_overflow_flag)
        else $error("high flag cleared without software");

    AST_LFLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        (inc_low && count_low_byte_q == 8'hFF) |=> (ctrl_q.low_byte_overflow_flag && irq_status_q[1]))
        else $error("low rollover missed flag");

    AST_LOW_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq && !(irq_status_q[0] && irq_mask_q[0])) |-> (ctrl_q.low_byte_irq_enable && irq_mask_q[1]))
        else $error("low interrupt without enables");

    AST_SPLIT_LOW_FREE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.split_mode_select && !ctrl_q.run_control && tick_low && count_low_byte_q != 8'hFF
         && !wr_count) |=> (count_low_byte_q == $past(count_low_byte_q) + 8'h01))
        else $error("split low byte did not count while stopped");

    AST_STOP_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_q.run_control && !wr_count) |=> $stable(count_high_byte_q))
        else $error("high byte moved while stopped");

    AST_UNUSED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend_q && addr_q == ARTC_OFF_CTRL) |-> (hrdata[4] == 1'b0 && hrdata[1] == 1'b0))
        else $error("unused control bits read nonzero");

    AST_RELOAD_SPLIT_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.split_mode_select && inc_low && count_low_byte_q == 8'hFF && !wr_count)
        |=> (count_low_byte_q == $past(reload_low_q)))
        else $error("split low byte reload wrong");

    AST_CARRY_16: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_q.split_mode_select && inc_low && count_low_byte_q == 8'hFF
         && count_word != 16'hFFFF && !wr_count)
        |=> (count_low_byte_q == 8'h00
             && count_high_byte_q == $past(count_high_byte_q) + 8'h01))
        else $error("16-bit low byte rollover did not carry");

    AST_RUN_16: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ctrl_q.split_mode_select && ctrl_q.run_control && tick_low && count_word != 16'hFFFF
         && !wr_count) |=> (count_word == $past(count_word) + 16'h0001))
        else $error("16-bit count did not advance while running");

    AST_HIGH_SPLIT_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.split_mode_select && ctrl_q.run_control && tick_high
         && count_high_byte_q != 8'hFF && !wr_count)
        |=> (count_high_byte_q == $past(count_high_byte_q) + 8'h01))
        else $error("split high byte did not count while running");

    AST_LFLAG_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.low_byte_overflow_flag && !wr_ctrl) |=> ctrl_q.low_byte_overflow_flag)
        else $error("low flag cleared without software");

    AST_LOW_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_status_q[ARTC_IRQ_LOW] && irq_mask_q[ARTC_IRQ_LOW]
         && ctrl_q.low_byte_irq_enable) |-> irq)
        else $error("enabled low overflow gave no interrupt");

    AST_STATUS_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_status && hwdata[ARTC_IRQ_HIGH] && !ovf_high) |=> !irq_status_q[ARTC_IRQ_HIGH])
        else $error("high status bit not cleared by write one");

    AST_HSTAT_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_status_q[ARTC_IRQ_HIGH] && !wr_status) |=> irq_status_q[ARTC_IRQ_HIGH])
        else $error("high status bit dropped without software");

    AST_LSTAT_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_status_q[ARTC_IRQ_LOW] && !wr_status) |=> irq_status_q[ARTC_IRQ_LOW])
        else $error("low status bit dropped without software");
endmodule : artc_timer

/* artc_tb.sv */
// Self-checking bench for the auto-reload timer control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import artc_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic ext_clk_pin = 1'b0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic irq;
    int miscompares = 0;
    int n_compared = 0;
    logic [31:0] rd;
    localparam logic [31:0] A_REL = {24'h0, ARTC_OFF_RELOAD};
    localparam logic [31:0] A_CNT = {24'h0, ARTC_OFF_COUNT};
    localparam logic [31:0] A_CKS = {24'h0, ARTC_OFF_CLKSEL};
    localparam logic [31:0] A_STA = {24'h0, ARTC_OFF_IRQ_STATUS};
    localparam logic [31:0] A_MSK = {24'h0, ARTC_OFF_IRQ_MASK};
    localparam logic [31:0] A_CTL = {24'h0, ARTC_OFF_CTRL};
    // Address, write data, expected read-back
    logic [31:0] rows [7][3] = '{
        '{A_REL, 32'hFFFF_1234, 32'h0000_1234},
        '{A_CKS, 32'h0000_00FF, 32'h0000_0003},
        '{A_MSK, 32'h0000_00FF, 32'h0000_0003},
        '{A_CTL, 32'h0000_00FF, 32'h0000_00ED},
        '{A_CTL, 32'h0000_0012, 32'h0000_0000},
        '{32'h0000_0020, 32'h0000_FFFF, 32'h0},
        '{32'h0000_01C8, 32'h0000_00FF, 32'h0}
    };

    always #20 hclk = ~hclk;

    artc_timer artc_timer_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .ext_clk_pin(ext_clk_pin),
        .irq(irq)
    );

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Interrupt is compared at the falling edge, once the launching edge has settled
    task automatic chk_irq(input logic e);
        @(negedge hclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : chk_irq

    // One single transfer; holds each phase until hready is seen high
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= ARTC_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk({31'h0, hresp}, {31'h0, ARTC_HRESP_OKAY});
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask : wr

    task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(r & m, e);
    endtask : rchk

    // Bounded wait, the timer paces the interrupt
    task automatic wait_irq();
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
    endtask : wait_irq

    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk_irq(1'b0);
        rchk(A_CTL, 32'hFF, {24'h0, ARTC_CTRL_RESET});
        rchk(A_REL, 32'hFFFF_FFFF, {16'h0, ARTC_RELOAD_RESET});
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rchk(rows[i][0], 32'hFFFF_FFFF, rows[i][2]);
        end
        // Full 16-bit rollover with reload and interrupt
        wr(A_CKS, 32'h1);
        wr(A_STA, 32'h3);
        wr(A_CNT, 32'hFFFE);
        wr(A_MSK, 32'h1);
        wr(A_CTL, 32'h04);
        wait_irq();
        wr(A_CTL, 32'h80);
        rchk(A_CNT, 32'hFF00, 32'h1200);
        repeat (20) @(posedge hclk);
        rchk(A_CTL, 32'h80, 32'h80);
        rchk(A_STA, 32'h1, 32'h1);
        chk_irq(1'b1);
        wr(A_STA, 32'h1);
        chk_irq(1'b0);
        rchk(A_STA, 32'h1, 32'h0);
        // Low byte rollover inside 16-bit mode carries into the high byte
        wr(A_STA, 32'h3);
        wr(A_CTL, 32'h00);
        wr(A_CNT, 32'h10FE);
        wr(A_CTL, 32'h04);
        repeat (4) @(posedge hclk);
        // Flag read before any write could have set it
        rchk(A_CTL, 32'hC0, 32'h40);
        wr(A_CTL, 32'h40);
        rchk(A_CTL, 32'hFF, 32'h40);
        rchk(A_CNT, 32'hFF00, 32'h1100);
        rchk(A_STA, 32'h3, 32'h2);
        wr(A_MSK, 32'h2);
        chk_irq(1'b0);
        wr(A_CTL, 32'h60);
        chk_irq(1'b1);
        wr(A_MSK, 32'h0);
        chk_irq(1'b0);
        // Split mode: low byte runs with run bit clear, high byte held
        wr(A_STA, 32'h3);
        // Low interrupt enable goes back off before the timer runs again
        wr(A_CTL, 32'h00);
        wr(A_REL, 32'hAA00);
        wr(A_CKS, 32'h3);
        wr(A_CNT, 32'h50FE);
        wr(A_CTL, 32'h08);
        repeat (4) @(posedge hclk);
        rchk(A_CNT, 32'hFF00, 32'h5000);
        rchk(A_CTL, 32'hC0, 32'h40);
        wr(A_CNT, 32'hFF00);
        wr(A_MSK, 32'h1);
        wr(A_CTL, 32'h0C);
        wait_irq();
        rchk(A_CTL, 32'h80, 32'h80);
        wr(A_CTL, 32'h00);
        wr(A_STA, 32'h3);
        // System clock over 12: exactly 120 cycles of running
        wr(A_CKS, 32'h0);
        wr(A_CNT, 32'h0);
        wr(A_CTL, 32'h04);
        repeat (117) @(posedge hclk);
        wr(A_CTL, 32'h00);
        rchk(A_CNT, 32'hFFFF, 32'h000A);
        // External pin over 8: 16 rising edges give two counts
        wr(A_CNT, 32'h0);
        wr(A_CTL, 32'h05);
        repeat (16) begin
            ext_clk_pin <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_clk_pin <= 1'b0;
            repeat (4) @(posedge hclk);
        end
        repeat (10) @(posedge hclk);
        wr(A_CTL, 32'h01);
        rchk(A_CNT, 32'hFFFF, 32'h0002);
        finish_test();
    end
endmodule : testbench
